//--- hw/rnc_arb.sv
// Purpose: Shares the nvmem byte engine between host and local side
// Assumes: Both requesters hold req until done; engine pulses done once
// Notes:   Alternating priority when both ask in the same cycle
`timescale 1ns/10ps
module rnc_arb (
   input wire logic mclk,
   input wire logic reset,
   rnc_mem_if.server host,
   input wire logic loc_req,
   input wire logic loc_we,
   input wire logic [15:0] loc_addr,
   input wire logic [7:0] loc_wdata,
   output logic loc_done,
   output logic [7:0] loc_rdata,
   output logic loc_fail,
   output logic eng_req,
   output logic eng_we,
   output logic [15:0] eng_addr,
   output logic [7:0] eng_wdata,
   input wire logic eng_done,
   input wire logic [7:0] eng_rdata,
   input wire logic eng_fail
);

   rnc_pkg::rnc_owner_t owner_ff;
   logic prefer_loc_ff;
   logic pick_loc;

   // Fairness: the side not served last wins a tie
   assign pick_loc = loc_req && (!host.req || prefer_loc_ff);

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         owner_ff <= rnc_pkg::OWN_IDLE;
         prefer_loc_ff <= 1'b0;
      end else begin
         case (owner_ff)
            rnc_pkg::OWN_IDLE: begin
               if (pick_loc) begin
                  owner_ff <= rnc_pkg::OWN_LOCAL;
                  prefer_loc_ff <= 1'b0;
               end else if (host.req) begin
                  owner_ff <= rnc_pkg::OWN_HOST;
                  prefer_loc_ff <= 1'b1;
               end
            end
            rnc_pkg::OWN_HOST, rnc_pkg::OWN_LOCAL: begin
               if (eng_done) begin
                  owner_ff <= rnc_pkg::OWN_IDLE;
               end
            end
            default: owner_ff <= rnc_pkg::OWN_IDLE;
         endcase
      end
   end

   // Request is latched at grant so the engine sees stable fields
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         eng_we <= 1'b0;
         eng_addr <= rnc_pkg::NV_ADDR_RST;
         eng_wdata <= rnc_pkg::PORT_RST;
      end else if (owner_ff == rnc_pkg::OWN_IDLE) begin
         eng_we <= pick_loc ? loc_we : host.we;
         eng_addr <= pick_loc ? loc_addr : host.addr;
         eng_wdata <= pick_loc ? loc_wdata : host.wdata;
      end
   end

   assign eng_req = (owner_ff != rnc_pkg::OWN_IDLE);
   assign host.done = eng_done && (owner_ff == rnc_pkg::OWN_HOST);
   assign loc_done = eng_done && (owner_ff == rnc_pkg::OWN_LOCAL);
   assign host.rdata = eng_rdata;
   assign loc_rdata = eng_rdata;
   assign host.fail = eng_fail;
   assign loc_fail = eng_fail;

   a_req_held: assert property (
      @(posedge mclk) disable iff (reset)
      eng_req && !eng_done |=> eng_req && $stable(eng_addr))
      else $error("engine request dropped before done");

endmodule

//--- hw/rnc_ctrl.sv
// Purpose: Host reset and nvmem control/status register with interrupts
// Assumes: Plain register port; nvmem engine and local side elsewhere
// Notes:   Contract
`timescale 1ns/10ps
module rnc_ctrl (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic irq,
   output logic mailbox_flag_reset,
   output logic read_fifo_reset,
   output logic local_side_reset_out_n,
   input wire logic loc_req,
   input wire logic loc_we,
   input wire logic [15:0] loc_addr,
   input wire logic [7:0] loc_wdata,
   output logic loc_done,
   output logic [7:0] loc_rdata,
   output logic loc_fail,
   output logic eng_req,
   output logic eng_we,
   output logic [15:0] eng_addr,
   output logic [7:0] eng_wdata,
   input wire logic eng_done,
   input wire logic [7:0] eng_rdata,
   input wire logic eng_fail
);

   typedef enum logic {
      ST_IDLE,
      ST_BUSY
   } rnc_state_t;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Decode

   rnc_state_t state_ff;
   rnc_pkg::rnc_op_t op_ff;
   rnc_pkg::rnc_op_t wr_op;
   logic [7:0] port_ff;
   logic [15:0] nv_addr_ff;
   logic fail_ff;
   logic loc_rst_ff;
   logic [1:0] stat_ff;
   logic [1:0] mask_ff;
   logic [1:0] stat_set;
   logic [31:0] ctrl_view;
   logic [1:0] trig;
   logic wr_ctrl;
   logic busy;
   logic start;
   logic start_rw;
   logic host_done;

   rnc_mem_if host_ch ();

   assign wr_ctrl = reg_wr && hit(reg_addr, rnc_pkg::OFF_CTRL);
   assign wr_op = rnc_pkg::rnc_op_t'(reg_wdata[rnc_pkg::OP_HI:
                                               rnc_pkg::OP_LO]);
   assign busy = (state_ff == ST_BUSY);
   // A write while busy leaves the access field alone
   assign start = wr_ctrl && reg_wdata[rnc_pkg::BIT_ENABLE] && !busy;
   assign start_rw = start && (wr_op == rnc_pkg::OP_WRITE ||
                               wr_op == rnc_pkg::OP_READ);
   assign host_done = host_ch.done;

   ////////////////////////////////////////////////////////////////////////
   // Access sequencer

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_ff <= ST_IDLE;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (start_rw) begin
                  state_ff <= ST_BUSY;
               end
            end
            ST_BUSY: begin
               if (host_done) begin
                  state_ff <= ST_IDLE;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         op_ff <= rnc_pkg::OP_ADDR_LO;
      end else if (start) begin
         op_ff <= wr_op;
      end
   end

   // Address bytes are loaded one operation at a time
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         nv_addr_ff <= rnc_pkg::NV_ADDR_RST;
      end else if (start && wr_op == rnc_pkg::OP_ADDR_LO) begin
         nv_addr_ff[7:0] <= reg_wdata[rnc_pkg::PORT_HI:rnc_pkg::PORT_LO];
      end else if (start && wr_op == rnc_pkg::OP_ADDR_HI) begin
         nv_addr_ff[15:8] <= reg_wdata[rnc_pkg::PORT_HI:rnc_pkg::PORT_LO];
      end
   end

   // Port holds the last byte given by software or fetched by a read
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         port_ff <= rnc_pkg::PORT_RST;
      end else if (host_done && op_ff == rnc_pkg::OP_READ) begin
         port_ff <= host_ch.rdata;
      end else if (start) begin
         port_ff <= reg_wdata[rnc_pkg::PORT_HI:rnc_pkg::PORT_LO];
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         fail_ff <= 1'b0;
      end else if (start_rw) begin
         fail_ff <= 1'b0;
      end else if (host_done) begin
         fail_ff <= host_ch.fail;
      end
   end

   // Request fields come straight from held state, stable while busy
   assign host_ch.req = busy;
   assign host_ch.we = (op_ff == rnc_pkg::OP_WRITE);
   assign host_ch.addr = nv_addr_ff;
   assign host_ch.wdata = port_ff;

   rnc_arb u_arb (
      .mclk(mclk),
      .reset(reset),
      .host(host_ch.server),
      .loc_req(loc_req),
      .loc_we(loc_we),
      .loc_addr(loc_addr),
      .loc_wdata(loc_wdata),
      .loc_done(loc_done),
      .loc_rdata(loc_rdata),
      .loc_fail(loc_fail),
      .eng_req(eng_req),
      .eng_we(eng_we),
      .eng_addr(eng_addr),
      .eng_wdata(eng_wdata),
      .eng_done(eng_done),
      .eng_rdata(eng_rdata),
      .eng_fail(eng_fail)
   );

   ////////////////////////////////////////////////////////////////////////
   // Reset controls

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         loc_rst_ff <= 1'b0;
      end else if (wr_ctrl) begin
         loc_rst_ff <= reg_wdata[rnc_pkg::BIT_LOC_RST];
      end
   end

   assign local_side_reset_out_n = ~loc_rst_ff;

   assign trig[0] = wr_ctrl && reg_wdata[rnc_pkg::BIT_MBX_RST];
   assign trig[1] = wr_ctrl && reg_wdata[rnc_pkg::BIT_FIFO_RST];

   rnc_pulse u_pulse (
      .mclk(mclk),
      .reset(reset),
      .trig(trig),
      .pulse({read_fifo_reset, mailbox_flag_reset})
   );

   ////////////////////////////////////////////////////////////////////////
   // Interrupts

   assign stat_set[rnc_pkg::IRQ_DONE] = host_done;
   assign stat_set[rnc_pkg::IRQ_FAIL] = host_done && host_ch.fail;

   // Set wins over the clear-on-read so no event is lost
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         stat_ff <= '0;
      end else if (reg_rd && hit(reg_addr, rnc_pkg::OFF_IRQ_STAT)) begin
         stat_ff <= stat_set;
      end else begin
         stat_ff <= stat_ff | stat_set;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         mask_ff <= rnc_pkg::IRQ_MASK_RST;
      end else if (reg_wr && hit(reg_addr, rnc_pkg::OFF_IRQ_MASK)) begin
         mask_ff <= reg_wdata[rnc_pkg::IRQ_W-1:0];
      end
   end

   assign irq = |(stat_ff & mask_ff);

   ////////////////////////////////////////////////////////////////////////
   // Read back

   // Write-only and reserved bits are simply never placed here
   always_comb begin
      ctrl_view = '0;
      ctrl_view[rnc_pkg::BIT_ENABLE] = busy;
      ctrl_view[rnc_pkg::OP_HI:rnc_pkg::OP_LO] = op_ff;
      ctrl_view[rnc_pkg::BIT_FAIL] = fail_ff;
      ctrl_view[rnc_pkg::BIT_LOC_RST] = loc_rst_ff;
      ctrl_view[rnc_pkg::PORT_HI:rnc_pkg::PORT_LO] = port_ff;
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         reg_rdata <= rnc_pkg::RDATA_RST;
      end else if (!reg_rd) begin
         reg_rdata <= rnc_pkg::RDATA_RST;
      end else if (hit(reg_addr, rnc_pkg::OFF_CTRL)) begin
         reg_rdata <= ctrl_view;
      end else if (hit(reg_addr, rnc_pkg::OFF_IRQ_STAT)) begin
         reg_rdata <= {30'h0000_0000, stat_ff};
      end else if (hit(reg_addr, rnc_pkg::OFF_IRQ_MASK)) begin
         reg_rdata <= {30'h0000_0000, mask_ff};
      end else begin
         reg_rdata <= rnc_pkg::RDATA_RST;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   a_busy_start: assert property (
      start_rw |=> busy && host_ch.req)
      else $error("access start did not raise busy");

   a_addr_nobusy: assert property (
      start && !start_rw |=> !busy)
      else $error("address load made the block busy");

   a_addr_lo_load: assert property (
      start && wr_op == rnc_pkg::OP_ADDR_LO |=>
      nv_addr_ff[7:0] == $past(reg_wdata[23:16]))
      else $error("low address byte not loaded");

   a_fail_set: assert property (
      host_done && host_ch.fail |=> fail_ff && !busy)
      else $error("failed access not flagged");

   a_fail_clear: assert property (
      start_rw |=> !fail_ff)
      else $error("fail flag not cleared at start");

   a_mbx_pulse: assert property (
      trig[0] |=> mailbox_flag_reset ##1 (mailbox_flag_reset == $past(trig[0])))
      else $error("mailbox reset pulse wrong");

   a_fifo_pulse: assert property (
      trig[1] |=> read_fifo_reset)
      else $error("read fifo reset pulse missing");

   a_rsvd_zero: assert property (
      reg_rd && hit(reg_addr, rnc_pkg::OFF_CTRL) |=>
      reg_rdata[27:25] == 3'h0 && reg_rdata[15:0] == 16'h0000)
      else $error("write-only or reserved bits read nonzero");

   a_loc_rst_hold: assert property (
      loc_rst_ff && !wr_ctrl |=> !local_side_reset_out_n)
      else $error("local reset released without a write");

   a_loc_rst_set: assert property (
      wr_ctrl && reg_wdata[24] |=> !local_side_reset_out_n)
      else $error("local reset not driven");

   a_read_port: assert property (
      host_done && op_ff == rnc_pkg::OP_READ |=>
      port_ff == $past(host_ch.rdata))
      else $error("read byte not placed in port");

endmodule

//--- hw/rnc_mem_if.sv
// Purpose: Byte request channel toward the nvmem arbiter
// Assumes: Requester holds req until done, drops it the edge after
// Notes:   done, rdata and fail are valid in the done cycle only
`timescale 1ns/10ps
interface rnc_mem_if;
   logic req;
   logic we;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic done;
   logic [7:0] rdata;
   logic fail;

   modport requester (
      output req,
      output we,
      output addr,
      output wdata,
      input done,
      input rdata,
      input fail
   );

   modport server (
      input req,
      input we,
      input addr,
      input wdata,
      output done,
      output rdata,
      output fail
   );
endinterface

//--- hw/rnc_pkg.sv
// Purpose: Shared constants and types of the reset and nvmem control block
// Assumes: One clock domain, byte-wide external memory with 16-bit address
// Notes:   Offsets are byte addresses on the plain register port
package rnc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register port
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h04;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h08;

   ////////////////////////////////////////////////////////////////////////
   // Control register field positions
   localparam int BIT_ENABLE = 31;
   localparam int OP_HI = 30;
   localparam int OP_LO = 29;
   localparam int BIT_FAIL = 28;
   localparam int BIT_MBX_RST = 27;
   localparam int BIT_FIFO_RST = 25;
   localparam int BIT_LOC_RST = 24;
   localparam int PORT_HI = 23;
   localparam int PORT_LO = 16;

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status and mask layout
   localparam int IRQ_W = 2;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_FAIL = 1;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] PORT_RST = 8'h00;
   localparam logic [15:0] NV_ADDR_RST = 16'h0000;
   localparam logic [1:0] IRQ_MASK_RST = 2'h0;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {
      OP_ADDR_LO,
      OP_ADDR_HI,
      OP_WRITE,
      OP_READ
   } rnc_op_t;

   typedef enum logic [1:0] {
      OWN_IDLE,
      OWN_HOST,
      OWN_LOCAL
   } rnc_owner_t;

endpackage

//--- hw/rnc_pulse.sv
// Purpose: One-cycle registered pulses for the self-clearing reset bits
// Assumes: Trigger is the qualified register write
// Notes:   Back-to-back writes give back-to-back pulses
`timescale 1ns/10ps
module rnc_pulse (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [1:0] trig,
   output logic [1:0] pulse
);

   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_pulse
         always_ff @(posedge mclk or posedge reset) begin
            if (reset) begin
               pulse[i] <= 1'b0;
            end else begin
               pulse[i] <= trig[i];
            end
         end
      end
   endgenerate

endmodule

//--- test/rnc_nv_model.sv
// Purpose: Behavioural byte engine with nvmem array behind the arbiter
// Assumes: One done pulse per engine request, after dly wait cycles
// Notes:   Data and fail lines toggle outside the done cycle
`timescale 1ns/10ps
module rnc_nv_model (
   input wire logic mclk,
   input wire logic reset,
   input wire logic eng_req,
   input wire logic eng_we,
   input wire logic [15:0] eng_addr,
   input wire logic [7:0] eng_wdata,
   input wire logic [3:0] dly,
   input wire logic fail_on,
   output logic eng_done,
   output logic [7:0] eng_rdata,
   output logic eng_fail
);
   logic [7:0] mem [logic [15:0]];
   logic [3:0] cnt;

   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         cnt <= 4'h0;
         eng_done <= 1'b0;
         eng_rdata <= 8'h00;
         eng_fail <= 1'b0;
      end else begin
         eng_done <= 1'b0;
         // Stale lines must not look like a valid answer
         eng_rdata <= ~eng_rdata;
         eng_fail <= ~eng_fail;
         cnt <= 4'h0;
         if (eng_req && !eng_done && cnt != dly) begin
            cnt <= cnt + 4'h1;
         end else if (eng_req && !eng_done) begin
            eng_done <= 1'b1;
            eng_fail <= fail_on;
            if (!eng_we) begin
               eng_rdata <= mem.exists(eng_addr) ? mem[eng_addr] : 8'h00;
            end else if (!fail_on) begin
               // A failed write leaves the array untouched
               mem[eng_addr] = eng_wdata;
            end
         end
      end
   end
endmodule

//--- test/test_rnc_ctrl.sv
// Purpose: Self-checking bench of the reset and nvmem control register
// Assumes: Byte engine model answers every engine request once
// Notes:   Expected values come from a bench-side map of the array
`timescale 1ns/10ps
`define CHK(g, e) chk(32'(g), 32'(e))
module test_rnc_ctrl;
   logic mclk, reset, reg_wr, reg_rd, irq;
   logic mailbox_flag_reset, read_fifo_reset, local_side_reset_out_n;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rq;
   logic loc_req, loc_we, loc_done, loc_fail, eng_req, eng_we;
   logic [15:0] loc_addr, eng_addr, a, b;
   logic [7:0] loc_wdata, loc_rdata, eng_wdata, eng_rdata, d;
   logic eng_done, eng_fail, fail_on, p_mbx, p_fifo, t_fail, t_lrst;
   logic [3:0] dly;
   logic [1:0] t_op;
   logic [7:0] t_port;
   logic [7:0] ref_mem [int];
   int n_mismatch, n_tests;

   rnc_ctrl dut_u (
      .mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .irq, .mailbox_flag_reset, .read_fifo_reset, .local_side_reset_out_n,
      .loc_req, .loc_we, .loc_addr, .loc_wdata, .loc_done, .loc_rdata,
      .loc_fail, .eng_req, .eng_we, .eng_addr, .eng_wdata, .eng_done,
      .eng_rdata, .eng_fail
   );

   rnc_nv_model nv_u (
      .mclk, .reset, .eng_req, .eng_we, .eng_addr, .eng_wdata, .dly,
      .fail_on, .eng_done, .eng_rdata, .eng_fail
   );

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h, expected %h", $time, g, e);
      end
   endtask

   task automatic close_out();
      $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // The gap edge keeps two strobe assignments out of one time step
   task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
      reg_addr <= ad;
      reg_wdata <= wd;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
      p_mbx = mailbox_flag_reset;
      p_fifo = read_fifo_reset;
      @(posedge mclk);
   endtask

   task automatic rd(input logic [7:0] ad);
      reg_addr <= ad;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      rq = reg_rdata;
      @(posedge mclk);
   endtask

   function automatic logic [31:0] view(input logic busy);
      return {busy, t_op, t_fail, 3'b000, t_lrst, t_port, 16'h0000};
   endfunction

   task automatic op(input logic [1:0] o, input logic [7:0] pb);
      wr(rnc_pkg::OFF_CTRL, {1'b1, o, 5'h00, pb, 16'h0000});
      t_op = o;
      t_port = pb;
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 40; i++) begin
         rd(rnc_pkg::OFF_CTRL);
         if (rq[31] === 1'b0) return;
      end
      n_mismatch++;
      close_out();
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic host_acc(input logic [15:0] ha, input logic w,
                           input logic [7:0] hd);
      op(2'b00, ha[7:0]);
      op(2'b01, ha[15:8]);
      op({1'b1, ~w}, w ? hd : t_port);
      t_fail = 1'b0;
      rd(rnc_pkg::OFF_CTRL);
      `CHK(rq, view(1'b1));
      wait_idle();
      t_fail = fail_on;
      if (w && !fail_on) ref_mem[ha] = hd;
      if (!w) t_port = ref_mem.exists(ha) ? ref_mem[ha] : 8'h00;
      `CHK(rq, view(1'b0));
   endtask

   task automatic loc_acc(input logic [15:0] la, input logic w,
                          input logic [7:0] ld);
      loc_addr <= la;
      loc_we <= w;
      loc_wdata <= ld;
      loc_req <= 1'b1;
      for (int i = 0; i < 60; i++) begin
         @(posedge mclk);
         #1;
         if (loc_done === 1'b1) begin
            `CHK(loc_fail, 1'b0);
            if (!w) `CHK(loc_rdata, ref_mem[la]);
            if (w) ref_mem[la] = ld;
            @(posedge mclk);
            loc_req <= 1'b0;
            return;
         end
      end
      n_mismatch++;
      close_out();
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h39f7_daaf));
      reset = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      loc_req = 1'b0;
      loc_we = 1'b0;
      loc_addr = 16'h0000;
      loc_wdata = 8'h00;
      dly = 4'h1;
      fail_on = 1'b0;
      t_op = 2'b00;
      t_fail = 1'b0;
      t_lrst = 1'b0;
      t_port = 8'h00;
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      rd(rnc_pkg::OFF_CTRL);
      `CHK(rq, 32'h0000_0000);
      `CHK(local_side_reset_out_n, 1'b1);
      rd(8'h0C);
      `CHK(rq, 32'h0000_0000);
      rd(rnc_pkg::OFF_IRQ_MASK);
      `CHK(rq, 32'h0000_0000);
      // Write-only pulses, reserved bits and the held local reset
      wr(rnc_pkg::OFF_CTRL, 32'h0F00_FFFF);
      `CHK({p_mbx, p_fifo}, 2'b11);
      t_lrst = 1'b1;
      rd(rnc_pkg::OFF_CTRL);
      `CHK(rq, view(1'b0));
      `CHK({mailbox_flag_reset, read_fifo_reset}, 2'b00);
      repeat (8) @(posedge mclk);
      `CHK(local_side_reset_out_n, 1'b0);
      wr(rnc_pkg::OFF_CTRL, 32'h0000_0000);
      t_lrst = 1'b0;
      `CHK(local_side_reset_out_n, 1'b1);
      // Random write then read back, fast and slow engine
      for (int k = 0; k < 6; k++) begin
         a = 16'($urandom);
         d = 8'($urandom);
         dly <= 4'($urandom_range(0, 6));
         host_acc(a, 1'b1, d);
         host_acc(a, 1'b0, 8'h00);
      end
      `CHK(irq, 1'b0);
      wr(rnc_pkg::OFF_IRQ_MASK, 32'h0000_0001);
      `CHK(irq, 1'b1);
      rd(rnc_pkg::OFF_IRQ_STAT);
      `CHK(rq, 32'h0000_0001);
      `CHK(irq, 1'b0);
      // Failed read and write, then the flag clears at the next start
      fail_on <= 1'b1;
      host_acc(a, 1'b0, 8'h00);
      host_acc(a ^ 16'h0001, 1'b1, 8'hA5);
      rd(rnc_pkg::OFF_IRQ_STAT);
      `CHK(rq[1], 1'b1);
      fail_on <= 1'b0;
      dly <= 4'h6;
      host_acc(a, 1'b0, 8'h00);
      // Both sides at once; software keeps them on different bytes
      b = a ^ 16'h8000;
      d = 8'($urandom);
      fork
         host_acc(a, 1'b0, 8'h00);
         loc_acc(b, 1'b1, d);
      join
      loc_acc(b, 1'b0, 8'h00);
      host_acc(b, 1'b0, 8'h00);
      close_out();
   end
endmodule
